/* core/mmd_decoder.sv */
// Purpose: program, internal data and external data address decoder
// Assumes: one clock hclk at 100 MHz, AHB-Lite register slave
// Notes: routing results are registered one cycle after the request
//
// Functional notes
// - primary flash block is 512 sectors of 128 bytes each.
// - secondary flash block is 64 sectors of 128 bytes each.
// - low seven address bits pick byte, upper bits pick sector.
// - select 01, 10 or 11 hides secondary block from fetch.
// - select 00 fetches 0000H-1FFFH from secondary block, rest primary.
// - select loads from reset cause and start-up bit at reset; software may change low bit.
// - reset cause decides high bit; start-up bit decides low bit.
// - start-up bit reads 0 when programmed, 1 when unprogrammed.
// - low RAM direct or indirect; upper half indirect RAM, direct registers.
// - above 7FH indirect goes to upper RAM, direct to special registers.
// - disable clear, external moves below 0300H reach 768 on-chip bytes.
// - disable clear, wide moves 0300H-FFFFH go external with strobes.
// - disable clear, narrow moves reach on-chip bytes 0-0FFH, no strobes.
// - disable set, all external moves go out with strobes asserted.
// - stack accesses always stay in the 256 internal RAM bytes.
// - two 16-bit data pointers, chosen by the pointer select bit.
// - incrementing the second aux register toggles the pointer select.
`timescale 1ns/1ns
module mmd_decoder #(
	parameter int PRIMARY_SECTORS = 512,
	parameter int SECONDARY_SECTORS = 64
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic por_resetn,
	input wire mmd_pkg::mmd_cause_t reset_cause,
	input wire logic startup_block_bit,
	// register bus
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic hready,
	input wire logic [31:0] hwdata,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// program fetch and in-application programming
	input wire logic fetch_valid,
	input wire logic [15:0] fetch_addr,
	input wire logic iap_valid,
	input wire logic iap_secondary,
	input wire logic [15:0] iap_addr,
	output logic flash_valid,
	output logic flash_secondary,
	output logic flash_in_range,
	output logic [8:0] flash_sector,
	output logic [6:0] flash_byte,
	// internal data space
	input wire logic data_valid,
	input wire logic data_indirect,
	input wire logic data_stack,
	input wire logic [7:0] data_addr,
	output logic ram_select,
	output logic special_register_select,
	output logic [7:0] internal_addr,
	// external moves
	input wire logic xmove_valid,
	input wire logic xmove_wide,
	input wire logic xmove_write,
	input wire logic [7:0] xmove_reg_addr,
	output logic onchip_xram_select,
	output logic [9:0] onchip_xram_addr,
	output logic ext_rd_n,
	output logic ext_wr_n,
	output logic port_zero_drive,
	output logic [7:0] port_zero_addr,
	output logic port_two_drive,
	output logic [7:0] port_two_addr,
	output logic [15:0] data_pointer
);
	import mmd_pkg::*;

	localparam int PSEC_W = $clog2(PRIMARY_SECTORS);
	localparam int SSEC_W = $clog2(SECONDARY_SECTORS);

	// register state
	logic bsel_lo_reg;
	logic bsel_hi_reg;
	logic init_done_reg;
	mmd_cause_t cause_reg;
	logic startup_seen_reg;
	logic onchip_xram_disable;
	logic pointer_select;
	logic gen_flag_reg;
	logic [15:0] data_pointer_zero;
	logic [15:0] data_pointer_one;
	// bus state
	logic wr_pend_reg;
	logic rd_pend_reg;
	logic [7:0] addr_reg;

	// sector number of a program address within its block
	function automatic logic [8:0] sector_of(input logic [15:0] a);
		sector_of = a[15:MMD_SECTOR_BITS];
	endfunction : sector_of

	// bus decode
	wire bus_take = hsel && hready && htrans[1];
	wire take_wr = bus_take && hwrite;
	wire take_rd = bus_take && !hwrite;
	wire wr_cfg = wr_pend_reg && (addr_reg == MMD_OFS_FLASH_CFG);
	wire wr_aux = wr_pend_reg && (addr_reg == MMD_OFS_AUX_CTRL);
	wire wr_aux2 = wr_pend_reg && (addr_reg == MMD_OFS_AUX_SECOND);
	wire wr_dp0 = wr_pend_reg && (addr_reg == MMD_OFS_DATA_POINTER_ZERO);
	wire wr_dp1 = wr_pend_reg && (addr_reg == MMD_OFS_DATA_POINTER_ONE);
	wire wr_inc = wr_pend_reg && (addr_reg == MMD_OFS_AUX_INC);

	// read mux, unmapped words read as zero
	logic [31:0] rd_value;
	always_comb begin
		rd_value = 32'h0000_0000;
		case (addr_reg)
			MMD_OFS_FLASH_CFG: rd_value[1:0] = {bsel_hi_reg, bsel_lo_reg};
			MMD_OFS_AUX_CTRL: rd_value[MMD_BIT_XRAM_DIS] = onchip_xram_disable;
			MMD_OFS_AUX_SECOND: begin
				rd_value[MMD_BIT_PTR_SEL] = pointer_select;
				rd_value[MMD_BIT_GEN_FLAG] = gen_flag_reg;
			end
			MMD_OFS_DATA_POINTER_ZERO: rd_value[15:0] = data_pointer_zero;
			MMD_OFS_DATA_POINTER_ONE: rd_value[15:0] = data_pointer_one;
			MMD_OFS_STATUS: rd_value[3:0] = {startup_seen_reg, cause_reg,
				init_done_reg};
			default: rd_value = 32'h0000_0000;
		endcase
	end

	// bus phase tracking; a read takes one wait state so that a write in
	// the preceding data phase is already visible
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_reg <= 1'b0;
			rd_pend_reg <= 1'b0;
			addr_reg <= 8'h00;
			hreadyout <= 1'b1;
			hrdata <= 32'h0000_0000;
		end else begin
			wr_pend_reg <= take_wr;
			rd_pend_reg <= take_rd;
			if (bus_take) begin
				addr_reg <= {haddr[7:2], 2'b00};
			end
			hreadyout <= !take_rd;
			if (rd_pend_reg) begin
				hrdata <= rd_value;
			end
		end
	end

	// response is always OKAY
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hresp <= 1'b0;
		end else begin
			hresp <= 1'b0;
		end
	end

	// the high select bit survives watchdog resets; power-on and external resets
	// clear it and software resets set it, loaded once at the first edge after hresetn release
	always_ff @(posedge hclk or negedge por_resetn) begin
		if (!por_resetn) begin
			bsel_hi_reg <= MMD_RST_BSEL[MMD_BIT_BSEL_HI];
		end else if (!init_done_reg && hresetn) begin
			case (reset_cause)
				MMD_CAUSE_POWER: bsel_hi_reg <= 1'b0;
				MMD_CAUSE_EXTERNAL: bsel_hi_reg <= 1'b0;
				MMD_CAUSE_SOFTWARE: bsel_hi_reg <= 1'b1;
				default: bsel_hi_reg <= bsel_hi_reg; // watchdog
			endcase
		end
	end

	// low select bit: start-up bit at release, software afterwards
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			bsel_lo_reg <= MMD_RST_BSEL[MMD_BIT_BSEL_LO];
			init_done_reg <= 1'b0;
			cause_reg <= MMD_CAUSE_POWER;
			startup_seen_reg <= 1'b1;
		end else if (!init_done_reg) begin
			// programmed start-up bit (0) selects the 01 and x1 values
			bsel_lo_reg <= (startup_block_bit == MMD_STARTUP_PROGRAMMED);
			startup_seen_reg <= startup_block_bit;
			cause_reg <= reset_cause;
			init_done_reg <= 1'b1;
		end else if (wr_cfg) begin
			// the nonvolatile bit is an input only, so it never changes here
			bsel_lo_reg <= hwdata[MMD_BIT_BSEL_LO];
		end
	end

	// control registers and the two data pointers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			onchip_xram_disable <= MMD_RST_XRAM_DIS;
			pointer_select <= MMD_RST_PTR_SEL;
			gen_flag_reg <= 1'b0;
			data_pointer_zero <= MMD_RST_DATA_POINTER;
			data_pointer_one <= MMD_RST_DATA_POINTER;
		end else begin
			if (wr_aux) begin
				onchip_xram_disable <= hwdata[MMD_BIT_XRAM_DIS];
			end
			if (wr_aux2) begin
				pointer_select <= hwdata[MMD_BIT_PTR_SEL];
				gen_flag_reg <= hwdata[MMD_BIT_GEN_FLAG];
			end else if (wr_inc) begin
				// bit 1 is not built, so the carry dies and bit 0 toggles
				pointer_select <= !pointer_select;
			end
			if (wr_dp0) begin
				data_pointer_zero <= hwdata[15:0];
			end
			if (wr_dp1) begin
				data_pointer_one <= hwdata[15:0];
			end
		end
	end

	// program space routing, evaluated from the current select each access
	wire overlay_on = !bsel_hi_reg && !bsel_lo_reg;
	wire fetch_low = fetch_addr <= MMD_OVERLAY_TOP;
	wire fetch_sec = overlay_on && fetch_low;
	wire iap_low = iap_addr <= MMD_OVERLAY_TOP;
	// secondary block by programming is only reachable in its 8K window
	wire iap_ok = !iap_secondary || iap_low;
	wire [15:0] prog_addr = iap_valid ? iap_addr : fetch_addr;
	wire prog_sec = iap_valid ? iap_secondary : fetch_sec;
	wire [8:0] prog_sector = sector_of(prog_addr);
	wire [8:0] sec_sector = {{(9 - SSEC_W){1'b0}},
		prog_sector[SSEC_W-1:0]};
	wire [8:0] pri_sector = prog_sector[PSEC_W-1:0];

	// programming has priority over a fetch in the same cycle
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			flash_valid <= 1'b0;
			flash_secondary <= 1'b0;
			flash_in_range <= 1'b0;
			flash_sector <= 9'h000;
			flash_byte <= 7'h00;
		end else begin
			flash_valid <= fetch_valid || iap_valid;
			flash_secondary <= prog_sec;
			flash_in_range <= iap_valid ? iap_ok : 1'b1;
			flash_sector <= prog_sec ? sec_sector : pri_sector;
			flash_byte <= prog_addr[MMD_SECTOR_BITS-1:0];
		end
	end

	// internal data space: upper half splits by addressing style
	wire upper_half = data_addr > MMD_LOWER_RAM_TOP;
	// stack accesses act as indirect and never leave internal RAM
	wire as_indirect = data_indirect || data_stack;
	wire to_sfr = upper_half && !as_indirect;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ram_select <= 1'b0;
			special_register_select <= 1'b0;
			internal_addr <= 8'h00;
		end else begin
			ram_select <= data_valid && !to_sfr;
			special_register_select <= data_valid && to_sfr;
			internal_addr <= data_addr;
		end
	end

	// external move routing with the selected pointer
	wire [15:0] cur_pointer = pointer_select ? data_pointer_one
		: data_pointer_zero;
	wire wide_onchip = cur_pointer < MMD_XRAM_LIMIT;
	wire use_onchip = !onchip_xram_disable
		&& (!xmove_wide || wide_onchip);
	wire go_ext = xmove_valid && !use_onchip;
	wire [9:0] xram_target = xmove_wide ? cur_pointer[9:0]
		: {2'b00, xmove_reg_addr}; // narrow form stays below 100H
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			onchip_xram_select <= 1'b0;
			onchip_xram_addr <= 10'h000;
			ext_rd_n <= 1'b1;
			ext_wr_n <= 1'b1;
			port_zero_drive <= 1'b0;
			port_zero_addr <= 8'h00;
			port_two_drive <= 1'b0;
			port_two_addr <= 8'h00;
			data_pointer <= MMD_RST_DATA_POINTER;
		end else begin
			onchip_xram_select <= xmove_valid && use_onchip;
			onchip_xram_addr <= xram_target;
			ext_rd_n <= !(go_ext && !xmove_write);
			ext_wr_n <= !(go_ext && xmove_write);
			port_zero_drive <= go_ext;
			port_zero_addr <= xmove_wide ? cur_pointer[7:0]
				: xmove_reg_addr;
			port_two_drive <= go_ext && xmove_wide;
			port_two_addr <= cur_pointer[15:8];
			data_pointer <= cur_pointer;
		end
	end
endmodule : mmd_decoder

/* core/mmd_pkg.sv */
// Purpose: shared constants of the memory map decoder
// Assumes: AHB-Lite register port, 32-bit data, word aligned registers
// Notes: register offsets are byte addresses
package mmd_pkg;
	// register byte offsets
	localparam logic [7:0] MMD_OFS_FLASH_CFG = 8'h00;
	localparam logic [7:0] MMD_OFS_AUX_CTRL = 8'h04;
	localparam logic [7:0] MMD_OFS_AUX_SECOND = 8'h08;
	localparam logic [7:0] MMD_OFS_DATA_POINTER_ZERO = 8'h0C;
	localparam logic [7:0] MMD_OFS_DATA_POINTER_ONE = 8'h10;
	localparam logic [7:0] MMD_OFS_AUX_INC = 8'h14;
	localparam logic [7:0] MMD_OFS_STATUS = 8'h18;
	// field positions
	localparam int MMD_BIT_BSEL_LO = 0;
	localparam int MMD_BIT_BSEL_HI = 1;
	localparam int MMD_BIT_XRAM_DIS = 0;
	localparam int MMD_BIT_PTR_SEL = 0;
	localparam int MMD_BIT_GEN_FLAG = 3;
	// reset values
	localparam logic [1:0] MMD_RST_BSEL = 2'h0;
	localparam logic MMD_RST_XRAM_DIS = 1'b0;
	localparam logic MMD_RST_PTR_SEL = 1'b0;
	localparam logic [15:0] MMD_RST_DATA_POINTER = 16'h0000;
	// address map figures
	localparam int MMD_SECTOR_BITS = 7;
	localparam logic [15:0] MMD_OVERLAY_TOP = 16'h1FFF;
	localparam logic [15:0] MMD_XRAM_LIMIT = 16'h0300;
	localparam logic [7:0] MMD_LOWER_RAM_TOP = 8'h7F;
	// reset causes as reported by the reset controller
	typedef enum logic [1:0] {
		MMD_CAUSE_POWER = 2'b00,
		MMD_CAUSE_EXTERNAL = 2'b01,
		MMD_CAUSE_WATCHDOG = 2'b10,
		MMD_CAUSE_SOFTWARE = 2'b11
	} mmd_cause_t;
	// start-up bit encoding
	localparam logic MMD_STARTUP_PROGRAMMED = 1'b0;
endpackage : mmd_pkg

/* tb/mmd_props.sv */
// Purpose: port checker for the memory map decoder
// Assumes: routing answers one cycle after each request
// Notes: the pointer is held steady around external moves
`timescale 1ns/1ns
module mmd_props (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic fetch_valid,
	input wire logic [15:0] fetch_addr,
	input wire logic iap_valid,
	input wire logic iap_secondary,
	input wire logic [15:0] iap_addr,
	input wire logic flash_valid,
	input wire logic flash_secondary,
	input wire logic flash_in_range,
	input wire logic [6:0] flash_byte,
	input wire logic data_valid,
	input wire logic data_indirect,
	input wire logic data_stack,
	input wire logic [7:0] data_addr,
	input wire logic ram_select,
	input wire logic special_register_select,
	input wire logic xmove_valid,
	input wire logic xmove_wide,
	input wire logic xmove_write,
	input wire logic onchip_xram_select,
	input wire logic ext_rd_n,
	input wire logic ext_wr_n,
	input wire logic port_zero_drive,
	input wire logic port_two_drive,
	input wire logic [15:0] data_pointer
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// a plain fetch; programming access would win the cycle
	sequence s_fetch;
		fetch_valid && !iap_valid;
	endsequence
	sequence s_wide_rd;
		xmove_valid && xmove_wide && !xmove_write && data_pointer >= 16'h0300;
	endsequence
	// requests and their registered routing
	property p_valid; fetch_valid |=> flash_valid; endproperty
	a_valid: assert property (p_valid)
		else $error("fetch not answered");
	property p_byte; s_fetch |=> flash_byte == $past(fetch_addr[6:0]);
	endproperty
	a_byte: assert property (p_byte)
		else $error("byte index wrong");
	property p_high; fetch_valid && !iap_valid && fetch_addr > 16'h1fff
		|=> !flash_secondary; endproperty
	a_high: assert property (p_high)
		else $error("high fetch in secondary");
	property p_iap; iap_valid && iap_secondary |=> flash_secondary &&
		flash_in_range == ($past(iap_addr) <= 16'h1fff); endproperty
	a_iap: assert property (p_iap)
		else $error("programming route wrong");
	property p_sfr; data_valid && !data_indirect && !data_stack &&
		data_addr[7] |=> special_register_select && !ram_select; endproperty
	a_sfr: assert property (p_sfr)
		else $error("direct upper access not a register");
	property p_ram; data_valid && (data_indirect || data_stack ||
		!data_addr[7]) |=> ram_select && !special_register_select; endproperty
	a_ram: assert property (p_ram)
		else $error("ram access misrouted");
	property p_wide; s_wide_rd |=> !ext_rd_n && port_two_drive &&
		!onchip_xram_select; endproperty
	a_wide: assert property (p_wide)
		else $error("wide move not external");
	property p_quiet; onchip_xram_select |-> ext_rd_n && ext_wr_n &&
		!port_zero_drive && !port_two_drive; endproperty
	a_quiet: assert property (p_quiet)
		else $error("on-chip move touched ports");
	property p_narrow; xmove_valid && !xmove_wide |=> !port_two_drive;
	endproperty
	a_narrow: assert property (p_narrow)
		else $error("narrow move drove port two");
endmodule : mmd_props
bind mmd_decoder mmd_props mmd_props_inst (.hclk, .hresetn, .fetch_valid,
	.fetch_addr, .iap_valid, .iap_secondary, .iap_addr, .flash_valid,
	.flash_secondary, .flash_in_range, .flash_byte, .data_valid,
	.data_indirect, .data_stack, .data_addr, .ram_select,
	.special_register_select, .xmove_valid, .xmove_wide, .xmove_write,
	.onchip_xram_select, .ext_rd_n, .ext_wr_n, .port_zero_drive,
	.port_two_drive, .data_pointer);

/* tb/mmd_ext_mem.sv */
// Purpose: external data memory on the multiplexed port bus
// Assumes: the address is valid while a strobe is low
// Notes: keeps only the last address seen
`timescale 1ns/1ns
module mmd_ext_mem (
	input wire logic hclk,
	input wire logic ext_rd_n,
	input wire logic ext_wr_n,
	input wire logic port_two_drive,
	input wire logic [7:0] port_two_addr,
	input wire logic [7:0] port_zero_addr,
	output logic [15:0] last_addr
);
	// high byte counts only while port two carries it (wide moves)
	always_ff @(posedge hclk) begin
		if (!ext_rd_n || !ext_wr_n) begin
			last_addr <= {port_two_drive ? port_two_addr : 8'h00, port_zero_addr};
		end
	end
endmodule : mmd_ext_mem

/* tb/testbench.sv */
// Purpose: directed bench for the memory map decoder
// Assumes: write zero wait, read one wait, routing one cycle late
// Notes: tests are bus and core calls with expected values
`timescale 1ns/1ns
module testbench;
	import mmd_pkg::*;
	logic hclk = 1'b0, hresetn = 1'b0, por_resetn = 1'b0, hi = 1'b0;
	mmd_cause_t reset_cause = MMD_CAUSE_POWER;
	mmd_cause_t cs[4] = '{MMD_CAUSE_POWER, MMD_CAUSE_EXTERNAL,
		MMD_CAUSE_SOFTWARE, MMD_CAUSE_WATCHDOG};
	logic startup_block_bit = 1'b1, hsel = 1'b0, hwrite = 1'b0;
	logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, rd;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic fetch_valid = 1'b0, iap_valid = 1'b0, iap_secondary = 1'b0;
	logic [15:0] fetch_addr = 16'h0000, iap_addr = 16'h0000;
	logic data_valid = 1'b0, data_indirect = 1'b0, data_stack = 1'b0;
	logic xmove_valid = 1'b0, xmove_wide = 1'b0, xmove_write = 1'b0;
	logic [7:0] data_addr = 8'h00, xmove_reg_addr = 8'h00;
	wire logic [31:0] hrdata;
	wire logic hreadyout, hresp, flash_valid, flash_secondary, flash_in_range;
	wire logic [8:0] flash_sector;
	wire logic [6:0] flash_byte;
	wire logic ram_select, special_register_select, onchip_xram_select;
	wire logic ext_rd_n, ext_wr_n, port_zero_drive, port_two_drive;
	wire logic [7:0] internal_addr, port_zero_addr, port_two_addr;
	wire logic [9:0] onchip_xram_addr;
	wire logic [15:0] data_pointer, last_addr;
	wire logic hready = hreadyout;
	wire logic [17:0] fl = {flash_in_range, flash_secondary, flash_sector,
		flash_byte};
	wire logic [9:0] dt = {ram_select, special_register_select, internal_addr};
	wire logic [4:0] xm = {onchip_xram_select, ext_rd_n, ext_wr_n,
		port_zero_drive, port_two_drive};
	int num_errors = 0, n_tests = 0;
	mmd_decoder mmd_decoder_inst (.hclk, .hresetn, .por_resetn, .reset_cause,
		.startup_block_bit, .hsel, .haddr, .htrans, .hwrite, .hsize, .hready,
		.hwdata, .hrdata, .hreadyout, .hresp, .fetch_valid, .fetch_addr,
		.iap_valid, .iap_secondary, .iap_addr, .flash_valid, .flash_secondary,
		.flash_in_range, .flash_sector, .flash_byte, .data_valid,
		.data_indirect, .data_stack, .data_addr, .ram_select,
		.special_register_select, .internal_addr, .xmove_valid, .xmove_wide,
		.xmove_write, .xmove_reg_addr, .onchip_xram_select, .onchip_xram_addr,
		.ext_rd_n, .ext_wr_n, .port_zero_drive, .port_zero_addr,
		.port_two_drive, .port_two_addr, .data_pointer);
	mmd_ext_mem mmd_ext_mem_inst (.hclk, .ext_rd_n, .ext_wr_n,
		.port_two_drive, .port_two_addr, .port_zero_addr, .last_addr);
	// free running core clock
	initial begin
		forever #5 hclk = ~hclk;
	end
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			num_errors++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task wrap_up;
		$display("comparisons %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : wrap_up
	// one single transfer; no latency assumed, hready decides each phase
	task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= wr;
		haddr <= {24'h00_0000, a};
		do @(posedge hclk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hready !== 1'b1);
		rd = hrdata;
	endtask : bus
	// one-cycle core request; f = secondary, indirect, stack, wide, write
	task go(input logic [3:0] v, input logic [15:0] a, input logic [7:0] b,
		input logic [4:0] f);
		@(posedge hclk);
		{fetch_valid, iap_valid, data_valid, xmove_valid} <= v;
		fetch_addr <= a;
		iap_addr <= a;
		data_addr <= b;
		xmove_reg_addr <= b;
		{iap_secondary, data_indirect, data_stack, xmove_wide, xmove_write} <= f;
		@(posedge hclk);
		{fetch_valid, iap_valid, data_valid, xmove_valid} <= 4'h0;
		#1;
	endtask : go
	task rst(input mmd_cause_t c, input logic sb);
		@(posedge hclk);
		hresetn <= 1'b0;
		reset_cause <= c;
		startup_block_bit <= sb;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		repeat (3) @(posedge hclk);
	endtask : rst
	// watchdog: the tests need well under two thousand cycles
	initial begin
		#200000;
		num_errors++;
		wrap_up();
	end
	initial begin
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		por_resetn <= 1'b1;
		// select field after every reset kind and start-up bit
		foreach (cs[i]) for (int sb = 0; sb < 2; sb++) begin
			rst(cs[i], sb[0]);
			if (cs[i] == MMD_CAUSE_SOFTWARE) hi = 1'b1;
			else if (cs[i] != MMD_CAUSE_WATCHDOG) hi = 1'b0;
			bus(1'b0, MMD_OFS_FLASH_CFG, 32'h0000_0000);
			chk(rd, {30'h000_0000, hi, ~sb[0]});
		end
		rst(MMD_CAUSE_POWER, 1'b1);
		$display("reset test done");
		// overlay on, then hidden
		go(4'h8, 16'h0100, 8'h00, 5'h00);
		chk(fl, {2'h3, 9'h002, 7'h00});
		go(4'h8, 16'h2085, 8'h00, 5'h00);
		chk(fl, {2'h2, 9'h041, 7'h05});
		go(4'h8, 16'hffff, 8'h00, 5'h00);
		chk(fl, {2'h2, 9'h1ff, 7'h7f});
		go(4'h4, 16'h0100, 8'h00, 5'h00);
		chk(fl, {2'h2, 9'h002, 7'h00});
		// switch made while no fetch is in flight in the low 8K
		bus(1'b1, MMD_OFS_FLASH_CFG, 32'h0000_0001);
		bus(1'b0, MMD_OFS_FLASH_CFG, 32'h0000_0000);
		chk(rd, 32'h0000_0001);
		go(4'h8, 16'h0100, 8'h00, 5'h00);
		chk(fl, {2'h2, 9'h002, 7'h00});
		go(4'h4, 16'h1fff, 8'h00, 5'h10);
		chk(fl, {2'h3, 9'h03f, 7'h7f});
		$display("flash test done");
		// internal data space by addressing style
		go(4'h2, 16'h0000, 8'h90, 5'h00);
		chk(dt, {2'h1, 8'h90});
		go(4'h2, 16'h0000, 8'h90, 5'h08);
		chk(dt, {2'h2, 8'h90});
		go(4'h2, 16'h0000, 8'h90, 5'h04);
		chk(dt, {2'h2, 8'h90});
		go(4'h2, 16'h0000, 8'h10, 5'h00);
		chk(dt, {2'h2, 8'h10});
		$display("data test done");
		// external moves, disable clear then set
		bus(1'b1, MMD_OFS_DATA_POINTER_ZERO, 32'h0000_0400);
		go(4'h1, 16'h0000, 8'h00, 5'h02);
		chk(xm, 5'h07);
		chk(port_two_addr, 8'h04);
		@(posedge hclk);
		#1;
		chk(last_addr, 16'h0400);
		bus(1'b1, MMD_OFS_DATA_POINTER_ONE, 32'h0000_00a0);
		bus(1'b1, MMD_OFS_AUX_INC, 32'h0000_0000);
		bus(1'b0, MMD_OFS_AUX_SECOND, 32'h0000_0000);
		chk(rd, 32'h0000_0001);
		go(4'h1, 16'h0000, 8'h00, 5'h03);
		chk(xm, 5'h1c);
		chk(onchip_xram_addr, 10'h0a0);
		chk(data_pointer, 16'h00a0);
		go(4'h1, 16'h0000, 8'h55, 5'h00);
		chk(xm, 5'h1c);
		chk(onchip_xram_addr, 10'h055);
		bus(1'b1, MMD_OFS_AUX_CTRL, 32'h0000_0001);
		go(4'h1, 16'h0000, 8'h55, 5'h00);
		chk(xm, 5'h06);
		@(posedge hclk);
		#1;
		chk(last_addr, 16'h0055);
		go(4'h1, 16'h0000, 8'h00, 5'h03);
		chk(xm, 5'h0b);
		@(posedge hclk);
		#1;
		chk(last_addr, 16'h00a0);
		bus(1'b1, MMD_OFS_AUX_INC, 32'h0000_0000);
		bus(1'b0, 8'h3c, 32'h0000_0000);
		chk(rd, 32'h0000_0000);
		chk(hresp, 32'h0000_0000);
		chk(data_pointer, 16'h0400);
		$display("move test done");
		wrap_up();
	end
endmodule : testbench
